// [core/sensor_regs_pkg.sv]
// constants, types and register map of the sensor result register bank
// assumes a byte-addressed register space of 16-bit words
package sensor_regs_pkg;

  typedef logic [7:0]  addr_t;
  typedef logic [15:0] word_t;

  // register offsets
  localparam addr_t OFS_POWER_COMMAND      = 8'h22;
  localparam addr_t OFS_TEMPERATURE_RESULT = 8'h2E;
  localparam addr_t OFS_PRESSURE_RESULT    = 8'h30;
  localparam addr_t OFS_SNAPSHOT_STATUS    = 8'h32;
  localparam addr_t OFS_LIVE_STATUS        = 8'h36;

  // command codes
  localparam word_t CMD_SLEEP = 16'h6C32;
  localparam word_t CMD_RESET = 16'hB169;

  // reset values
  localparam word_t RST_POWER_COMMAND   = 16'h0000;
  localparam word_t RST_RESULT          = 16'h0000;
  localparam word_t RST_STATUS          = 16'h0000;

  // status bit positions
  localparam int BIT_IDLE              = 0;
  localparam int BIT_PRES_FRESH        = 3;
  localparam int BIT_TEMP_FRESH        = 4;
  localparam int BIT_SUPPLY_FAIL       = 7;
  localparam int BIT_BRIDGE_CHECK_FAIL = 8;
  localparam int BIT_SATURATION        = 10;
  localparam int BIT_COM_CRC_ERROR     = 11;
  localparam int BIT_PRES_MISSED       = 14;
  localparam int BIT_TEMP_MISSED       = 15;

  // event bits that hardware sets and that a write of one clears
  localparam word_t EVENT_MASK  = 16'hC998;
  // snapshot bits that mirror the live status continuously
  localparam word_t MIRROR_MASK = 16'hFFE1;

  typedef enum {
    SEL_NONE, SEL_COMMAND, SEL_TEMP, SEL_PRES, SEL_SNAPSHOT, SEL_LIVE
  } reg_sel_t;

  typedef enum {
    PWR_STARTUP, PWR_MEASURE, PWR_SLEEP, PWR_CRC_FAULT
  } power_state_t;

endpackage

// [core/link_access_port.sv]
// link-side request port of the sensor register bank
// runs on the link clock; talks to the core by a toggle handshake
module link_access_port (
  input  wire logic                  link_clk_in,
  input  wire logic                  resetn_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  input  wire sensor_regs_pkg::addr_t addr_in,
  input  wire sensor_regs_pkg::word_t wdata_in,
  input  wire logic                  ack_toggle_in,
  input  wire sensor_regs_pkg::word_t core_rdata_in,
  output logic                       req_toggle_out,
  output logic                       req_write_out,
  output sensor_regs_pkg::addr_t     req_addr_out,
  output sensor_regs_pkg::word_t     req_wdata_out,
  output sensor_regs_pkg::word_t     rdata_out,
  output logic                       done_out,
  output logic                       busy_out
);
  import sensor_regs_pkg::*;

  logic rst_meta;
  logic link_resetn;
  logic ack_meta;
  logic ack_sync;
  logic ack_seen;

  // reset brought into the link domain
  always_ff @(posedge link_clk_in) begin
    rst_meta    <= resetn_in;
    link_resetn <= rst_meta;
  end

  // acknowledge toggle synchroniser
  always_ff @(posedge link_clk_in) begin
    if (!link_resetn) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack_toggle_in;
      ack_sync <= ack_meta;
    end
  end

  // one request in flight; address and data held until acknowledged
  always_ff @(posedge link_clk_in) begin
    if (!link_resetn) begin
      ack_seen       <= 1'b0;
      req_toggle_out <= 1'b0;
      req_write_out  <= 1'b0;
      req_addr_out   <= '0;
      req_wdata_out  <= RST_STATUS;
      rdata_out      <= RST_STATUS;
      done_out       <= 1'b0;
      busy_out       <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (busy_out && (ack_sync != ack_seen)) begin
        ack_seen  <= ack_sync;
        rdata_out <= core_rdata_in; // stable since the ack toggled
        done_out  <= 1'b1;
        busy_out  <= 1'b0;
      end else if (!busy_out && (wr_in || rd_in)) begin
        req_write_out  <= wr_in;  // write wins if both are raised
        req_addr_out   <= addr_in;
        req_wdata_out  <= wdata_in;
        req_toggle_out <= ~req_toggle_out;
        busy_out       <= 1'b1;
      end
    end
  end

endmodule

// [core/sensor_result_register_bank.sv]
// register bank holding results, status and power command of the sensor
// measurement logic and flag sources share ref_clk_in; the register
// requests arrive on the link clock and cross by a toggle handshake
// result loads and health pulses are single strobes on ref_clk_in
// resetn_in is synchronous and active low; the link side sees it
// two link clock edges later through its own synchroniser
// every output comes straight from a flop of its own clock
module sensor_result_register_bank (
  input  wire logic                   ref_clk_in,
  input  wire logic                   resetn_in,
  // register requests, link clock domain
  input  wire logic                   link_clk_in,
  input  wire logic                   link_wr_in,
  input  wire logic                   link_rd_in,
  input  wire sensor_regs_pkg::addr_t link_addr_in,
  input  wire sensor_regs_pkg::word_t link_wdata_in,
  output sensor_regs_pkg::word_t      link_rdata_out,
  output logic                        link_done_out,
  output logic                        link_busy_out,
  // measurement and health sources, ref clock domain
  input  wire logic                   temp_load_in,
  input  wire sensor_regs_pkg::word_t temp_value_in,
  input  wire logic                   pres_load_in,
  input  wire sensor_regs_pkg::word_t pres_value_in,
  input  wire logic                   crc_done_in,
  input  wire logic                   crc_pass_in,
  input  wire logic                   idle_in,
  input  wire logic                   saturation_in,
  input  wire logic                   supply_fail_flag_in,
  input  wire logic                   bridge_check_fail_flag_in,
  input  wire logic                   com_crc_error_in,
  // power control
  output logic                        sleep_out,
  output logic                        reload_out,
  output logic                        crc_fault_out
);
  import sensor_regs_pkg::*;

  // handshake wires from the link port
  // held steady by the link port while its request is in flight
  logic  req_toggle;
  logic  req_write;
  addr_t req_addr;
  word_t req_wdata;

  // core side of the handshake
  // only req_sync is read by logic, never req_meta
  logic  req_meta;
  logic  req_sync;
  logic  req_seen;
  logic  ack_toggle;
  word_t acc_rdata;

  // register state
  power_state_t power_state;
  word_t        temperature_result;
  word_t        pressure_result;

  // live flags, status levels and captured snapshot bits
  word_t        live_events;
  logic         idle_q;
  logic         saturation_q;
  logic         snap_pres_fresh;
  logic         snap_temp_fresh;

  // decoded access
  logic     access;
  logic     do_read;
  logic     do_write;
  reg_sel_t sel;

  // command and status write strobes
  logic     cmd_write;
  logic     live_write;
  logic     cmd_sleep;
  logic     cmd_reset;

  // measurement loads and result reads
  logic     temp_upd;
  logic     pres_upd;
  logic     rd_temp;
  logic     rd_pres;

  // register views and flag updates
  word_t    live_status;
  word_t    snapshot_status;
  word_t    event_set;
  word_t    event_clr;
  word_t    read_mux;

  // map an offset onto a register
  // offsets outside the map decode to none and read as zero
  function automatic reg_sel_t decode(input addr_t a);
    reg_sel_t s;
    s = SEL_NONE;
    // each offset names exactly one register
    case (a)
      OFS_POWER_COMMAND:      s = SEL_COMMAND;
      OFS_TEMPERATURE_RESULT: s = SEL_TEMP;
      OFS_PRESSURE_RESULT:    s = SEL_PRES;
      OFS_SNAPSHOT_STATUS:    s = SEL_SNAPSHOT;
      OFS_LIVE_STATUS:        s = SEL_LIVE;
      default:                s = SEL_NONE;
    endcase
    return s;
  endfunction

  // write strobe aimed at one register
  function automatic logic write_hit(input logic     w,
                                     input reg_sel_t s,
                                     input reg_sel_t r);
    return w && (s == r);
  endfunction

  // link-side request port
  // one request at a time; it answers with done after the ack
  link_access_port u_link (
    .link_clk_in    (link_clk_in),
    .resetn_in      (resetn_in),
    .wr_in          (link_wr_in),
    .rd_in          (link_rd_in),
    .addr_in        (link_addr_in),
    .wdata_in       (link_wdata_in),
    .ack_toggle_in  (ack_toggle),
    .core_rdata_in  (acc_rdata),
    .req_toggle_out (req_toggle),
    .req_write_out  (req_write),
    .req_addr_out   (req_addr),
    .req_wdata_out  (req_wdata),
    .rdata_out      (link_rdata_out),
    .done_out       (link_done_out),
    .busy_out       (link_busy_out)
  );

  // request toggle synchroniser
  // two flops, the toggle comes from the link clock domain
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= req_toggle;
      req_sync <= req_meta;
    end
  end

  // one access per toggle; address and data are held by the link port
  always_comb begin
    // a toggle that differs from the last seen one is a new access
    access   = (req_sync != req_seen);
    sel      = decode(req_addr);
    do_read  = access && !req_write;
    do_write = access && req_write;
    // result reads drive the fresh clears and snapshot copies
    rd_temp  = do_read && (sel == SEL_TEMP);
    rd_pres  = do_read && (sel == SEL_PRES);
    // only command and live status accept writes
    cmd_write  = write_hit(do_write, sel, SEL_COMMAND);
    live_write = write_hit(do_write, sel, SEL_LIVE);
    // a command acts only for its exact code
    cmd_sleep = cmd_write && (req_wdata == CMD_SLEEP);
    cmd_reset = cmd_write && (req_wdata == CMD_RESET);
  end

  // results only move while measuring after a passed check
  // loads during startup, sleep or a check fault are dropped
  always_comb begin
    temp_upd = temp_load_in && (power_state == PWR_MEASURE);
    pres_upd = pres_load_in && (power_state == PWR_MEASURE);
  end

  // live status view: events plus status levels, reserved bits zero
  // status-type bits follow their level and cannot be cleared
  always_comb begin
    live_status                 = live_events & EVENT_MASK;
    // levels overwrite the masked event bits
    live_status[BIT_IDLE]       = idle_q;
    live_status[BIT_SATURATION] = saturation_q;
  end

  // snapshot view: mirrors plus the two captured fresh flags
  // bits 1, 2 and the reserved positions read as zero
  always_comb begin
    snapshot_status                 = live_status & MIRROR_MASK;
    snapshot_status[BIT_PRES_FRESH] = snap_pres_fresh;
    snapshot_status[BIT_TEMP_FRESH] = snap_temp_fresh;
  end

  // read data selection
  // the write-only command and unmapped offsets read as zero
  always_comb begin
    // sel stays valid while the link port holds the address
    case (sel)
      SEL_COMMAND:  read_mux = RST_POWER_COMMAND;
      SEL_TEMP:     read_mux = temperature_result;
      SEL_PRES:     read_mux = pressure_result;
      SEL_SNAPSHOT: read_mux = snapshot_status;
      SEL_LIVE:     read_mux = live_status;
      default:      read_mux = RST_STATUS;
    endcase
  end

  // answer and acknowledge each access
  // write answers carry zero so the link sees no stale data
  // read data settles here before the ack toggle reaches the link
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      req_seen   <= 1'b0;
      ack_toggle <= 1'b0;
      acc_rdata  <= RST_STATUS;
    end else if (access) begin
      // the seen copy closes this access
      req_seen   <= req_sync;
      ack_toggle <= ~ack_toggle;
      acc_rdata  <= req_write ? RST_STATUS : read_mux;
    end
  end

  // power state: startup waits for the check, sleep and reset commands
  // reload_out is held high through resetn and pulses for one cycle on the reset command
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      power_state   <= PWR_STARTUP;
      sleep_out     <= 1'b0;
      reload_out    <= 1'b1;
      crc_fault_out <= 1'b0;
    end else begin
      // the reload request is a one-cycle pulse by default
      reload_out <= 1'b0;
      // the reset command wins over sleep and over a check fault
      if (cmd_reset) begin
        power_state   <= PWR_STARTUP;
        sleep_out     <= 1'b0;
        reload_out    <= 1'b1;
        crc_fault_out <= 1'b0;
      end else if (cmd_sleep) begin
        // sleep is left only by the reset command or by resetn
        power_state <= PWR_SLEEP;
        sleep_out   <= 1'b1;
      end else begin
        case (power_state)
          PWR_STARTUP: begin
            // startup ends when the configuration check reports
            if (crc_done_in && crc_pass_in) begin
              power_state <= PWR_MEASURE;
            end else if (crc_done_in) begin
              power_state   <= PWR_CRC_FAULT;
              crc_fault_out <= 1'b1;
            end
          end
          // the other states hold until a command or resetn
          PWR_MEASURE:   power_state <= PWR_MEASURE;
          PWR_SLEEP:     power_state <= PWR_SLEEP;
          PWR_CRC_FAULT: power_state <= PWR_CRC_FAULT;
          default:       power_state <= PWR_STARTUP;
        endcase
      end
    end
  end

  // result registers; content invalid until the first load
  // a reset command empties both until the next passed check
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in || cmd_reset) begin
      temperature_result <= RST_RESULT;
      pressure_result    <= RST_RESULT;
    end else begin
      if (temp_upd) begin
        temperature_result <= temp_value_in;
      end
      // both may load in one cycle, each with its own strobe
      if (pres_upd) begin
        pressure_result <= pres_value_in;
      end
    end
  end

  // event sources and clear requests for the live flags
  // missed flags rise when an update finds its fresh flag set
  always_comb begin
    event_set = '0;
    event_set[BIT_TEMP_FRESH]        = temp_upd;
    event_set[BIT_PRES_FRESH]        = pres_upd;
    event_set[BIT_TEMP_MISSED]       = temp_upd
                                       && live_events[BIT_TEMP_FRESH];
    event_set[BIT_PRES_MISSED]       = pres_upd
                                       && live_events[BIT_PRES_FRESH];
    // health pulses from the supply, bridge and link checks
    event_set[BIT_SUPPLY_FAIL]       = supply_fail_flag_in;
    event_set[BIT_BRIDGE_CHECK_FAIL] = bridge_check_fail_flag_in;
    event_set[BIT_COM_CRC_ERROR]     = com_crc_error_in;
    // write-one-to-clear from the live status register
    event_clr = '0;
    if (live_write) begin
      event_clr = req_wdata & EVENT_MASK;
    end
    // a result read clears its own fresh flag
    event_clr[BIT_TEMP_FRESH] = event_clr[BIT_TEMP_FRESH] || rd_temp;
    event_clr[BIT_PRES_FRESH] = event_clr[BIT_PRES_FRESH] || rd_pres;
  end

  // sticky events: a new event in the clearing cycle survives
  // positions outside the event mask never hold a one
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in || cmd_reset) begin
      live_events <= RST_STATUS;
    end else begin
      // clear first, then set, so the set wins
      live_events <= ((live_events & ~event_clr) | event_set)
                     & EVENT_MASK;
    end
  end

  // status levels follow their hardware condition
  // one ref cycle late, like every registered status view
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      idle_q       <= 1'b0;
      saturation_q <= 1'b0;
    end else begin
      // same-clock sources, so no synchroniser is needed
      idle_q       <= idle_in;
      saturation_q <= saturation_in;
    end
  end

  // fresh flags captured into the snapshot on a result read
  // the copy takes the live flag before the same read clears it
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in || cmd_reset) begin
      snap_pres_fresh <= 1'b0;
      snap_temp_fresh <= 1'b0;
    end else begin
      if (rd_pres) begin
        snap_pres_fresh <= live_events[BIT_PRES_FRESH];
      end
      // each read updates only its own snapshot bit
      if (rd_temp) begin
        snap_temp_fresh <= live_events[BIT_TEMP_FRESH];
      end
    end
  end

endmodule

// [verif/sensor_bank_sva.sv]
// checker for the sensor result register bank, on its ports only
// bound into every instance of the bank after the module
module sensor_bank_sva (
  input wire logic                   ref_clk_in,
  input wire logic                   resetn_in,
  input wire logic                   link_clk_in,
  input wire logic                   link_wr_in,
  input wire logic                   link_rd_in,
  input wire sensor_regs_pkg::word_t link_rdata_out,
  input wire logic                   link_done_out,
  input wire logic                   link_busy_out,
  input wire logic                   crc_done_in,
  input wire logic                   crc_pass_in,
  input wire logic                   sleep_out,
  input wire logic                   reload_out,
  input wire logic                   crc_fault_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import sensor_regs_pkg::*;
  logic last_wr;

  // remembers whether the access in flight is a write
  always_ff @(posedge link_clk_in) begin
    if (!link_busy_out && (link_wr_in || link_rd_in)) begin
      last_wr <= link_wr_in;
    end
  end

  // power control outputs
  chk_reload_pulse: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    reload_out |=> !reload_out) else $error("reload pulse too long");
  chk_sleep_holds: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    sleep_out |=> sleep_out || reload_out) else $error("sleep lost");
  chk_crc_fail_sets: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    crc_done_in && !crc_pass_in |=> crc_fault_out) else $error("no fault");
  chk_fault_sticky: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    crc_fault_out |=> crc_fault_out || reload_out) else $error("fault lost");
  // link handshake and answers
  chk_take_busy: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    !link_busy_out && (link_wr_in || link_rd_in) |=> link_busy_out)
    else $error("request not taken");
  chk_answer_bound: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    $rose(link_busy_out) |-> ##[1:12] link_done_out) else $error("no done");
  chk_done_pulse: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    link_done_out |=> !link_done_out) else $error("done too long");
  chk_busy_released: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    link_done_out |-> !link_busy_out) else $error("busy with done");
  chk_write_zero: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    link_done_out && last_wr |-> link_rdata_out == 16'h0000)
    else $error("write answer not zero");
  chk_rdata_hold: assert property (
    @(posedge link_clk_in) disable iff (!resetn_in)
    $changed(link_rdata_out) |-> link_done_out) else $error("rdata moved");
endmodule

bind sensor_result_register_bank sensor_bank_sva chk (
  .ref_clk_in, .resetn_in, .link_clk_in, .link_wr_in, .link_rd_in,
  .link_rdata_out, .link_done_out, .link_busy_out, .crc_done_in,
  .crc_pass_in, .sleep_out, .reload_out, .crc_fault_out
);

// [verif/link_host_model.sv]
// host model on the register link: one access at a time
// assumes a free-running link clock; the bench calls its tasks
module link_host_model (
  input  wire logic                   link_clk_in,
  input  wire sensor_regs_pkg::word_t rdata_in,
  input  wire logic                   done_in,
  output logic                        wr_out,
  output logic                        rd_out,
  output sensor_regs_pkg::addr_t      addr_out,
  output sensor_regs_pkg::word_t      wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import sensor_regs_pkg::*;

  // idle link at time zero
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end

  // request held to its taking edge, then wait for done
  task automatic access(input logic wr, input addr_t a, input word_t d,
                        input int gap, output word_t q);
    q = 16'hDEAD;
    repeat (gap) @(posedge link_clk_in);
    @(posedge link_clk_in);
    wr_out <= wr;
    rd_out <= !wr;
    addr_out <= a;
    wdata_out <= d;
    @(posedge link_clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;  // no stale value after release
    wdata_out <= ~d;
    // answer taken at the rising edge where done is sampled high
    for (int n = 0; n < 20; n++) begin
      @(posedge link_clk_in);
      if (done_in === 1'b1) begin
        q = rdata_in;
        break;
      end
    end
  endtask

  // poll live status until both fresh flags have shown up
  task automatic wait_fresh(output logic ok);
    word_t s;
    word_t seen;
    seen = 16'h0000;
    ok = 1'b0;
    for (int n = 0; n < 10 && !ok; n++) begin
      access(1'b0, OFS_LIVE_STATUS, 16'h0000, 1, s);
      seen = seen | s;
      ok = seen[BIT_PRES_FRESH] & seen[BIT_TEMP_FRESH];
    end
  endtask
endmodule

// [verif/test_sensor_result_register_bank.sv]
// self-checking bench for the sensor result register bank
// host model drives the link; measurement inputs are driven here
module test_sensor_result_register_bank;
  timeunit 1ns;
  timeprecision 100ps;
  import sensor_regs_pkg::*;
  logic  ref_clk_in = 1'b0, link_clk_in = 1'b0, resetn_in = 1'b0;
  logic  temp_load_in = 1'b0, pres_load_in = 1'b0, crc_done_in = 1'b0;
  logic  crc_pass_in = 1'b0, idle_in = 1'b0, saturation_in = 1'b0;
  logic  supply_fail_flag_in = 1'b0, bridge_check_fail_flag_in = 1'b0;
  logic  com_crc_error_in = 1'b0;
  word_t temp_value_in = 16'h0000, pres_value_in = 16'h0000;
  logic  link_wr_in, link_rd_in, link_done_out, link_busy_out;
  logic  sleep_out, reload_out, crc_fault_out;
  addr_t link_addr_in;
  word_t link_wdata_in, link_rdata_out;
  int    bad_count = 0, cmp_count = 0, cycles = 0, reloads = 0;

  sensor_result_register_bank DUT (
    .ref_clk_in, .resetn_in, .link_clk_in, .link_wr_in, .link_rd_in,
    .link_addr_in, .link_wdata_in, .link_rdata_out, .link_done_out,
    .link_busy_out, .temp_load_in, .temp_value_in, .pres_load_in,
    .pres_value_in, .crc_done_in, .crc_pass_in, .idle_in, .saturation_in,
    .supply_fail_flag_in, .bridge_check_fail_flag_in, .com_crc_error_in,
    .sleep_out, .reload_out, .crc_fault_out
  );
  link_host_model host (
    .link_clk_in, .rdata_in(link_rdata_out), .done_in(link_done_out),
    .wr_out(link_wr_in), .rd_out(link_rd_in), .addr_out(link_addr_in),
    .wdata_out(link_wdata_in)
  );

  // core clock and unrelated link clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  always #6 link_clk_in = ~link_clk_in;

  // watchdog and count of reload pulses
  always @(posedge ref_clk_in) begin
    cycles++;
    if (resetn_in && reload_out === 1'b1) reloads++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // level outputs are judged once settled
  task automatic settle();
    repeat (2) @(negedge ref_clk_in);
  endtask

  task automatic flag(input logic s, input logic e);
    check({15'h0, s}, {15'h0, e});
  endtask

  task automatic rd(input addr_t a, input word_t exp);
    word_t q;
    host.access(1'b0, a, 16'h0000, 0, q);
    check(q, exp);
  endtask

  task automatic wr(input addr_t a, input word_t d);
    word_t q;
    host.access(1'b1, a, d, 2, q);
    check(q, 16'h0000);
  endtask

  // one measurement pulse, temperature when t is high
  task automatic load(input logic t, input word_t v);
    @(posedge ref_clk_in);
    temp_load_in <= t;
    pres_load_in <= !t;
    temp_value_in <= v;
    pres_value_in <= v;
    @(posedge ref_clk_in);
    temp_load_in <= 1'b0;
    pres_load_in <= 1'b0;
  endtask

  task automatic crc(input logic pass);
    @(posedge ref_clk_in);
    crc_done_in <= 1'b1;
    crc_pass_in <= pass;
    @(posedge ref_clk_in);
    crc_done_in <= 1'b0;
  endtask

  // loads dropped before the configuration check passes
  task automatic t_startup();
    rd(OFS_POWER_COMMAND, 16'h0000);
    load(1'b1, 16'h1111);
    rd(OFS_TEMPERATURE_RESULT, 16'h0000);
    rd(OFS_SNAPSHOT_STATUS, 16'h0000);
    crc(1'b1);
    settle();
    flag(crc_fault_out, 1'b0);
  endtask

  // fresh flags, snapshot copies and read clears
  task automatic t_fresh();
    logic ok;
    load(1'b1, 16'h1234);
    load(1'b0, 16'hABCD);
    host.wait_fresh(ok);
    flag(ok, 1'b1);
    rd(OFS_LIVE_STATUS, 16'h0018);
    rd(OFS_SNAPSHOT_STATUS, 16'h0000);
    rd(OFS_PRESSURE_RESULT, 16'hABCD);
    rd(OFS_SNAPSHOT_STATUS, 16'h0008);
    rd(OFS_LIVE_STATUS, 16'h0010);
    rd(OFS_TEMPERATURE_RESULT, 16'h1234);
    rd(OFS_SNAPSHOT_STATUS, 16'h0018);
    rd(OFS_LIVE_STATUS, 16'h0000);
  endtask

  // unread updates raise missed flags, cleared by ones
  task automatic t_missed();
    load(1'b1, 16'h2222);
    load(1'b1, 16'h3333);
    load(1'b0, 16'h4444);
    load(1'b0, 16'h5555);
    rd(OFS_LIVE_STATUS, 16'hC018);
    wr(OFS_LIVE_STATUS, 16'hFFFF);
    rd(OFS_LIVE_STATUS, 16'h0000);
    rd(OFS_TEMPERATURE_RESULT, 16'h3333);
    rd(OFS_PRESSURE_RESULT, 16'h5555);
  endtask

  // protected and unmapped places ignore writes
  task automatic t_protect();
    addr_t list [4] = '{8'h2E, 8'h30, 8'h32, 8'h40};
    foreach (list[i]) wr(list[i], 16'h5A5A);
    rd(OFS_TEMPERATURE_RESULT, 16'h3333);
    rd(OFS_PRESSURE_RESULT, 16'h5555);
    rd(OFS_SNAPSHOT_STATUS, 16'h0000);
    rd(8'h40, 16'h0000);
  endtask

  // health flags mirrored into the snapshot
  task automatic t_mirror();
    @(posedge ref_clk_in);
    idle_in <= 1'b1;
    saturation_in <= 1'b1;
    supply_fail_flag_in <= 1'b1;
    bridge_check_fail_flag_in <= 1'b1;
    com_crc_error_in <= 1'b1;
    @(posedge ref_clk_in);
    supply_fail_flag_in <= 1'b0;
    bridge_check_fail_flag_in <= 1'b0;
    com_crc_error_in <= 1'b0;
    rd(OFS_SNAPSHOT_STATUS, 16'h0D81);
    @(posedge ref_clk_in);
    idle_in <= 1'b0;
    saturation_in <= 1'b0;
    rd(OFS_LIVE_STATUS, 16'h0980);
    wr(OFS_LIVE_STATUS, 16'hFFFF);
    rd(OFS_SNAPSHOT_STATUS, 16'h0000);
  endtask

  // sleep, ignored code, reset command, failed check
  task automatic t_power();
    int n;
    wr(OFS_POWER_COMMAND, CMD_SLEEP);
    settle();
    flag(sleep_out, 1'b1);
    load(1'b1, 16'h6666);
    rd(OFS_TEMPERATURE_RESULT, 16'h3333);
    wr(OFS_POWER_COMMAND, 16'h1111);
    settle();
    flag(sleep_out, 1'b1);
    n = reloads;
    wr(OFS_POWER_COMMAND, CMD_RESET);
    settle();
    flag(sleep_out, 1'b0);
    check(reloads[15:0], n[15:0] + 16'h0001);
    rd(OFS_TEMPERATURE_RESULT, 16'h0000);
    crc(1'b0);
    settle();
    flag(crc_fault_out, 1'b1);
    load(1'b1, 16'h7777);
    rd(OFS_TEMPERATURE_RESULT, 16'h0000);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    t_startup();
    t_fresh();
    t_missed();
    t_protect();
    t_mirror();
    t_power();
    complete_run();
  end
endmodule
